// ===== logic/arf_filter.sv
`timescale 1ns/100ps
`default_nettype none
`include "arf_consts.svh"
module arf_filter #(
	parameter int CHANNELS = 64,
	parameter int CW = 6
) (
	input wire logic clk,
	input wire logic arst_n,
	// receive engines
	input wire logic rx_valid,
	input wire arf_pkg::arf_rx_word_s rx_word,
	output logic rx_ready,
	// fifo writer (individual or merged, selected by rx_word.merged)
	output logic fifo_valid,
	output arf_pkg::arf_fifo_word_s fifo_word,
	input wire logic fifo_ready,
	// interrupt queue
	output logic iq_valid,
	output logic [31:0] iq_entry,
	// host register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [31:0] reg_rdata,
	output logic irq,
	output logic pci_irq
);
	initial begin
		if (CHANNELS > 64 || CW != 6) begin
			$error("arf_filter supports up to 64 channels with 6-bit index");
		end
	end

	typedef enum {
		ST_IDLE,
		ST_LOOKUP,
		ST_WAIT,
		ST_DECIDE,
		ST_SNAP,
		ST_FIFO,
		ST_HOST_WAIT
	} arf_state_e;

	arf_state_e state;
	arf_pkg::arf_rx_word_s cur;
	logic [3:0] fld;
	logic [1:0] loc;
	logic [31:0] global_reg;
	logic [18:0] sram_addr_reg;
	logic [31:0] host_rdata;
	logic host_pend;
	logic host_we_pend;
	logic [31:0] host_wdata;
	logic drop_evt;
	logic filt_evt;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;

	wire logic snap_mode = global_reg[`ARF_GLB_SNAPMODE];
	wire logic [7:0] cur_label = cur.data[7:0];
	wire logic [1:0] cur_sdi = cur.data[9:8];
	// mode 0 keys the slot on the word's SDI, mode 1 walks the four slots
	wire logic [1:0] snap_loc = snap_mode ? loc : cur_sdi;

	function automatic logic [18:0] snap_addr(input logic [5:0] ch, input logic [7:0] lbl,
			input logic [1:0] l);
		logic [31:0] off;
		off = {16'h0000, ch, lbl, l};
		return `ARF_SNAP_BASE + off[18:0];
	endfunction

	// host window excludes channel buffers so the fifo memory stays private
	function automatic logic host_ok(input logic [18:0] a);
		return a < `ARF_CHBUF_BASE;
	endfunction

	wire logic [18:0] filt_addr = `ARF_FILTER_BASE + {9'h000, cur_label, cur_sdi};
	wire logic [3:0] next_fld;
	logic [31:0] sram_rdata;
	assign next_fld = sram_rdata[{cur.ext_status, 2'b00} +: 4];

	wire logic host_write = reg_we && reg_addr == `ARF_REG_SDATA;
	wire logic host_read = reg_re && reg_addr == `ARF_REG_SDATA;
	// register strobes decoded once and shared by the register and irq logic
	wire logic wr_global = reg_we && reg_addr == `ARF_REG_GLOBAL;
	wire logic wr_saddr = reg_we && reg_addr == `ARF_REG_SADDR;
	wire logic wr_irq_clr = reg_we && reg_addr == `ARF_REG_IRQ_STAT;
	wire logic wr_irq_mask = reg_we && reg_addr == `ARF_REG_IRQ_MASK;

	// shared sram port: one owner per cycle, driven by state
	logic sram_req;
	logic sram_we;
	logic [18:0] sram_a;
	logic [31:0] sram_wd;
	always_comb begin
		sram_req = 1'b0;
		sram_we = 1'b0;
		sram_a = '0;
		sram_wd = '0;
		case (state)
			ST_LOOKUP: begin
				sram_req = 1'b1;
				sram_a = filt_addr;
			end
			ST_SNAP: begin
				sram_req = 1'b1;
				sram_we = 1'b1;
				sram_a = snap_addr(cur.channel, cur_label, snap_loc);
				if (!snap_mode) begin
					sram_wd = cur.data;
				end else begin
					case (loc)
						2'd0: sram_wd = cur.time_tag[31:0];
						2'd1: sram_wd = cur.time_tag[63:32];
						2'd2: sram_wd = 32'h0000_0000;
						default: sram_wd = cur.data;
					endcase
				end
			end
			ST_IDLE: begin
				if (host_pend) begin
					sram_req = 1'b1;
					sram_we = host_we_pend;
					sram_a = sram_addr_reg;
					sram_wd = host_wdata;
				end
			end
			default: begin
				sram_req = 1'b0;
			end
		endcase
	end

	arf_sram #(
		.AW(`ARF_SRAM_AW),
		.DEPTH(2 ** `ARF_SRAM_AW)
	) u_sram (
		.clk(clk),
		.req(sram_req),
		.we(sram_we),
		.addr(sram_a),
		.wdata(sram_wd),
		.rdata(sram_rdata)
	);

	// engine accepts a new word only when idle with no host access waiting
	assign rx_ready = state == ST_IDLE && !host_pend;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			cur <= '0;
			fld <= '0;
			loc <= '0;
			host_rdata <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					// host access goes first so the register port never stalls
					if (host_pend) begin
						state <= host_we_pend ? ST_IDLE : ST_HOST_WAIT;
					end else if (rx_valid) begin
						cur <= rx_word;
						state <= ST_LOOKUP;
					end
				end
				ST_HOST_WAIT: begin
					host_rdata <= sram_rdata;
					state <= ST_IDLE;
				end
				ST_LOOKUP: begin
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					// filter word is valid here, one cycle after the lookup read
					fld <= next_fld;
					loc <= 2'd0;
					state <= ST_DECIDE;
				end
				ST_DECIDE: begin
					if (!fld[`ARF_FLT_SSUP]) begin
						state <= ST_SNAP;
					end else if (!fld[`ARF_FLT_QSUP]) begin
						state <= ST_FIFO;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_SNAP: begin
					if (snap_mode && loc != 2'd3) begin
						loc <= loc + 2'd1;
					end else if (!fld[`ARF_FLT_QSUP]) begin
						state <= ST_FIFO;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_FIFO: begin
					if (fifo_ready) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// fifo handoff; the fifo memory itself is owned by the channel buffer logic
	assign fifo_valid = state == ST_FIFO;
	assign fifo_word = '{channel: cur.channel, merged: cur.merged, data: cur.data,
		time_tag: cur.time_tag};

	// interrupt queue entry fires once per word when enabled
	wire logic iq_fire = state == ST_DECIDE && fld[`ARF_FLT_IEN];
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			iq_valid <= 1'b0;
			iq_entry <= '0;
		end else begin
			iq_valid <= iq_fire;
			if (iq_fire) begin
				iq_entry <= {24'h00_0000, {2'b00, cur.channel} + `ARF_IQ_CH_OFFSET};
			end
		end
	end
	assign filt_evt = iq_fire;
	assign drop_evt = state == ST_DECIDE && fld[`ARF_FLT_SSUP] && fld[`ARF_FLT_QSUP];

	// host interrupt gated by global enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pci_irq <= 1'b0;
		end else begin
			pci_irq <= iq_fire && global_reg[`ARF_GLB_IEN];
		end
	end

	// register port
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			global_reg <= `ARF_GLOBAL_RST;
			sram_addr_reg <= '0;
			host_pend <= 1'b0;
			host_we_pend <= 1'b0;
			host_wdata <= '0;
		end else begin
			if (wr_global) begin
				global_reg <= {30'h0, reg_wdata[1:0]};
			end
			if (wr_saddr) begin
				sram_addr_reg <= reg_wdata[18:0];
			end
			// a new access replaces any pending one, which has already used the port only when the engine is in ST_IDLE
			if ((host_write || host_read) && host_ok(sram_addr_reg)) begin
				host_pend <= 1'b1;
				host_we_pend <= host_write;
				host_wdata <= reg_wdata;
			end else if (state == ST_IDLE && host_pend) begin
				host_pend <= 1'b0;
			end
		end
	end

	arf_irq #(
		.N(2)
	) u_irq (
		.clk(clk),
		.arst_n(arst_n),
		.event_pulse({drop_evt, filt_evt}),
		.clr_we(wr_irq_clr),
		.mask_we(wr_irq_mask),
		.wdata(reg_wdata[1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	logic [31:0] next_rdata;
	always_comb begin
		case (reg_addr)
			`ARF_REG_GLOBAL: next_rdata = global_reg;
			`ARF_REG_SADDR: next_rdata = {13'h0000, sram_addr_reg};
			`ARF_REG_SDATA: next_rdata = host_rdata;
			`ARF_REG_IRQ_STAT: next_rdata = {30'h0, irq_status};
			`ARF_REG_IRQ_MASK: next_rdata = {30'h0, irq_mask};
			`ARF_REG_STATUS: next_rdata = {28'h0, host_pend, rx_ready, fifo_valid, iq_valid};
			default: next_rdata = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else if (reg_re) begin
			reg_rdata <= next_rdata;
		end
	end
endmodule // arf_filter
`default_nettype wire

// ===== logic/arf_consts.svh
// Notes on behaviour
// - snapshot offset = zero, channel, label, location
// - channels 0-63, labels 000-377, SDI 0-3
// - mode 0 stores data at SDI location
// - mode 1 writes time lsw, msw, reserved, data
// - SRAM map: filter, snapshot, channel buffers
// - tx 0x20000, merged 0x30000, rx 0x40000
// - host reaches SRAM via address/data registers
// - filter word by label+SDI, eight 4-bit fields
// - bit0 queue, bit1 snapshot, bit2 interrupt suppress/enable
// - suppress flag 1 means word not recorded
// - queue flag acts on merged or individual FIFO
// - interrupt enable adds interrupt queue entry
// - global interrupt enable also raises host interrupt
// - FIFO memory hidden from host
// - queue entry is channel plus 64
// - snapshot entry keeps latest word only
// - snapshot mode is one global enable bit
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH
`define ARF_SRAM_AW 19
`define ARF_FILTER_BASE 19'h0_0000
`define ARF_SNAP_BASE 19'h1_0000
`define ARF_CHBUF_BASE 19'h2_0000
`define ARF_TXBUF_BASE 19'h2_0000
`define ARF_MRGBUF_BASE 19'h3_0000
`define ARF_RXBUF_BASE 19'h4_0000
`define ARF_RXBUF_SHIFT 11
`define ARF_FLT_QSUP 0
`define ARF_FLT_SSUP 1
`define ARF_FLT_IEN 2
`define ARF_IQ_CH_OFFSET 8'h40
`define ARF_REG_GLOBAL 4'h0
`define ARF_REG_SADDR 4'h1
`define ARF_REG_SDATA 4'h2
`define ARF_REG_IRQ_STAT 4'h3
`define ARF_REG_IRQ_MASK 4'h4
`define ARF_REG_STATUS 4'h5
`define ARF_GLB_IEN 0
`define ARF_GLB_SNAPMODE 1
`define ARF_GLOBAL_RST 32'h0000_0000
`define ARF_IRQ_FILTER 0
`define ARF_IRQ_DROP 1
`endif

// ===== logic/arf_pkg.sv
package arf_pkg;
	typedef struct packed {
		logic [5:0] channel;
		logic [2:0] ext_status;
		logic merged;
		logic [31:0] data;
		logic [63:0] time_tag;
	} arf_rx_word_s;
	typedef struct packed {
		logic [18:0] addr;
		logic [31:0] wdata;
		logic we;
	} arf_sram_req_s;
	typedef struct packed {
		logic [5:0] channel;
		logic merged;
		logic [31:0] data;
		logic [63:0] time_tag;
	} arf_fifo_word_s;
endpackage

// ===== logic/arf_sram.sv
`timescale 1ns/100ps
`default_nettype none
// on-board SRAM model as synchronous single-port memory, registered read data
module arf_sram #(
	parameter int AW = 19,
	parameter int DEPTH = 2 ** 19
) (
	input wire logic clk,
	input wire logic req,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	logic [31:0] mem [DEPTH];
	initial begin
		if (DEPTH > 2 ** AW) begin
			$error("arf_sram depth exceeds address space");
		end
	end
	always_ff @(posedge clk) begin
		if (req && we) begin
			mem[addr] <= wdata;
		end
		if (req && !we) begin
			rdata <= mem[addr];
		end
	end
endmodule // arf_sram
`default_nettype wire

// ===== logic/arf_irq.sv
`timescale 1ns/100ps
`default_nettype none
`include "arf_consts.svh"
// sticky status, write-one-to-clear, mask, level output
module arf_irq #(
	parameter int N = 2
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [N-1:0] event_pulse,
	input wire logic clr_we,
	input wire logic mask_we,
	input wire logic [N-1:0] wdata,
	output logic [N-1:0] status,
	output logic [N-1:0] mask,
	output logic irq
);
	logic [N-1:0] next_status;
	// set wins over a clear in the same cycle
	assign next_status = (status & ~(clr_we ? wdata : '0)) | event_pulse;
	assign irq = |(status & mask);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status <= '0;
			mask <= '0;
		end else begin
			status <= next_status;
			if (mask_we) begin
				mask <= wdata;
			end
		end
	end
endmodule // arf_irq
`default_nettype wire

// ===== sim/arf_filter_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module arf_filter_assertions (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic rx_valid,
	input wire arf_pkg::arf_rx_word_s rx_word,
	input wire logic rx_ready,
	input wire logic fifo_valid,
	input wire arf_pkg::arf_fifo_word_s fifo_word,
	input wire logic fifo_ready,
	input wire logic iq_valid,
	input wire logic [31:0] iq_entry,
	input wire logic pci_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [5:0] last_ch;
	logic last_m;
	logic [31:0] last_d;
	wire logic take = rx_valid && rx_ready;
	// remember the word in flight so outputs can be tied to it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_ch <= '0;
			last_m <= 1'b0;
			last_d <= '0;
		end else if (take) begin
			last_ch <= rx_word.channel;
			last_m <= rx_word.merged;
			last_d <= rx_word.data;
		end
	end
	sequence s_take;
		rx_valid && rx_ready;
	endsequence
	sequence s_busy;
		!rx_ready [*3];
	endsequence
	AST_BUSY_AFTER_TAKE: assert property (s_take |=> s_busy)
		else $error("receive port ready again too soon");
	AST_NO_EARLY_FIFO: assert property (s_take |=> !fifo_valid [*3])
		else $error("fifo output before lookup finished");
	AST_IQ_TIMING: assert property (iq_valid |-> $past(take, 4))
		else $error("interrupt entry not four cycles after take");
	AST_IQ_ENTRY: assert property (iq_valid |-> iq_entry == {24'h00_0000, 2'b01, last_ch})
		else $error("interrupt entry not channel plus 64");
	AST_PCI_WITH_IQ: assert property (pci_irq |-> iq_valid)
		else $error("host interrupt without queue entry");
	AST_FIFO_HOLD: assert property (fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_word))
		else $error("fifo word dropped or changed while stalled");
	AST_FIFO_SRC: assert property (fifo_valid |-> fifo_word.channel == last_ch && fifo_word.merged == last_m && fifo_word.data == last_d)
		else $error("fifo word does not match received word");
	AST_FIFO_BLOCKS_RX: assert property (fifo_valid |-> !rx_ready)
		else $error("new word accepted before fifo write done");
endmodule // arf_filter_assertions
bind arf_filter arf_filter_assertions u_arf_filter_assertions (.clk(clk), .arst_n(arst_n),
	.rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready), .fifo_valid(fifo_valid),
	.fifo_word(fifo_word), .fifo_ready(fifo_ready), .iq_valid(iq_valid), .iq_entry(iq_entry),
	.pci_irq(pci_irq));
`default_nettype wire

// ===== sim/arf_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module arf_far_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic send,
	input wire arf_pkg::arf_rx_word_s word_in,
	input wire logic stall,
	input wire logic rx_ready,
	input wire logic fifo_valid,
	output logic rx_valid,
	output arf_pkg::arf_rx_word_s rx_word,
	output logic fifo_ready
);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_valid <= 1'b0;
			rx_word <= '0;
			fifo_ready <= 1'b0;
		end else begin
			if (send) begin
				rx_valid <= 1'b1;
				rx_word <= word_in;
			end else if (rx_valid && rx_ready) begin
				rx_valid <= 1'b0;
				// scrambled once released so stale data never passes for valid
				rx_word <= ~rx_word;
			end
			fifo_ready <= stall ? ~fifo_ready : 1'b1;
		end
	end
endmodule // arf_far_model
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic send = 1'b0;
	logic stall = 1'b0;
	arf_pkg::arf_rx_word_s word_in = '0;
	arf_pkg::arf_rx_word_s rx_word;
	arf_pkg::arf_fifo_word_s fifo_word;
	logic rx_valid, rx_ready, fifo_valid, fifo_ready, iq_valid, irq, pci_irq;
	logic [31:0] iq_entry, reg_rdata, rd, iq_last;
	arf_pkg::arf_fifo_word_s got_w;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	int err_count = 0;
	int tests_run = 0;
	int iq_cnt = 0;
	int pci_cnt = 0;
	int got_cnt = 0;
	int k;
	arf_filter u_arf_filter (.clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_word(rx_word),
		.rx_ready(rx_ready), .fifo_valid(fifo_valid), .fifo_word(fifo_word),
		.fifo_ready(fifo_ready), .iq_valid(iq_valid), .iq_entry(iq_entry), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.irq(irq), .pci_irq(pci_irq));
	arf_far_model u_arf_far_model (.clk(clk), .arst_n(arst_n), .send(send), .word_in(word_in),
		.stall(stall), .rx_ready(rx_ready), .fifo_valid(fifo_valid), .rx_valid(rx_valid),
		.rx_word(rx_word), .fifo_ready(fifo_ready));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (iq_valid) begin
			iq_cnt++;
			iq_last = iq_entry;
		end
		if (pci_irq)
			pci_cnt++;
		if (fifo_valid && fifo_ready) begin
			got_cnt++;
			got_w = fifo_word;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic sram_wr(input logic [18:0] a, input logic [31:0] d);
		reg_wr(4'h1, {13'h0000, a});
		reg_wr(4'h2, d);
		repeat (4) @(posedge clk);
	endtask
	// first data read only starts the fetch
	task automatic sram_rd(input logic [18:0] a, output logic [31:0] d);
		reg_wr(4'h1, {13'h0000, a});
		reg_rd(4'h2, d);
		repeat (4) @(posedge clk);
		reg_rd(4'h2, d);
	endtask
	task automatic send_word(input logic [5:0] c, input logic [2:0] e, input logic m,
		input logic [31:0] d, input logic [63:0] t);
		int i;
		i = 0;
		@(posedge clk);
		send <= 1'b1;
		word_in <= '{channel: c, ext_status: e, merged: m, data: d, time_tag: t};
		@(posedge clk);
		send <= 1'b0;
		do begin
			@(posedge clk);
			#1 i++;
		end while (i < 60 && !(rx_ready && !rx_valid));
		repeat (2) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		// label 0xAA with SDI 2 indexes the same entry in either field order
		stall <= 1'b1;
		sram_wr(19'h0_02AA, 32'h0000_0000);
		send_word(6'd5, 3'd2, 1'b0, 32'h1234_5AAA, 64'h0);
		chk("fifo count", 32'd1, 32'(got_cnt));
		chk("fifo data", 32'h1234_5AAA, got_w.data);
		chk("fifo channel", 32'd5, {26'd0, got_w.channel});
		sram_rd({3'b001, 6'd5, 8'hAA, 2'd2}, rd);
		chk("snapshot mode0", 32'h1234_5AAA, rd);
		$display("test store done");
		reg_wr(4'h0, 32'h0000_0001);
		sram_wr(19'h0_02AA, 32'h0000_7000);
		send_word(6'd5, 3'd3, 1'b0, 32'h0BAD_0AAA, 64'h0);
		chk("fifo suppressed", 32'd1, 32'(got_cnt));
		chk("iq count", 32'd1, 32'(iq_cnt));
		chk("iq entry", 32'h0000_0045, iq_last);
		chk("pci count", 32'd1, 32'(pci_cnt));
		sram_rd({3'b001, 6'd5, 8'hAA, 2'd2}, rd);
		chk("snapshot kept", 32'h1234_5AAA, rd);
		reg_rd(4'h3, rd);
		chk("irq status", 32'h0000_0003, rd & 32'h0000_0003);
		chk("irq masked", 32'd0, {31'd0, irq});
		reg_wr(4'h4, 32'h0000_0001);
		#1 chk("irq raised", 32'd1, {31'd0, irq});
		reg_wr(4'h3, 32'h0000_0001);
		#1 chk("irq cleared", 32'd0, {31'd0, irq});
		$display("test suppress done");
		stall <= 1'b0;
		reg_wr(4'h0, 32'h0000_0002);
		sram_wr(19'h0_0155, 32'h0000_0000);
		send_word(6'd63, 3'd0, 1'b1, 32'h0000_0155, 64'h1111_2222_3333_4444);
		chk("fifo merged", 32'h0000_0155, got_w.data);
		chk("fifo merged flag", 32'd1, {31'd0, got_w.merged});
		chk("fifo channel", 32'd63, {26'd0, got_w.channel});
		chk("fifo tag msw", 32'h1111_2222, got_w.time_tag[63:32]);
		chk("iq unchanged", 32'd1, 32'(iq_cnt));
		for (k = 0; k < 4; k++) begin
			sram_rd({3'b001, 6'd63, 8'h55, 2'(k)}, rd);
			chk("snapshot mode1", k == 0 ? 32'h3333_4444 : k == 1 ? 32'h1111_2222 :
				k == 2 ? 32'h0000_0000 : 32'h0000_0155, rd);
		end
		reg_rd(4'hF, rd);
		chk("unmapped reg", 32'h0000_0000, rd);
		$display("test mode1 done");
		sram_rd(19'h0_02AA, rd);
		chk("filter readback", 32'h0000_7000, rd);
		sram_wr(19'h2_0000, 32'hDEAD_BEEF);
		sram_rd(19'h2_0000, rd);
		chk("hidden buffer", 32'h0000_7000, rd);
		$display("test host window done");
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		reg_rd(4'h0, rd);
		chk("global after reset", 32'h0000_0000, rd);
		reg_rd(4'h4, rd);
		chk("mask after reset", 32'h0000_0000, rd);
		reg_rd(4'h5, rd);
		chk("status after reset", 32'h0000_0004, rd);
		$display("test reset done");
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
